// *** bmp_backend_port.sv ***
// backend memory master port: request/grant, tenure and word accesses
// How it works
// - request held low from need until grant is seen low
// - grant seen low starts tenure and the memory accesses
// - tenure stays low until the access marked last finishes; several per tenure
// - write strobe bit one writes bits 15:8, bit zero writes bits 7:0
// - synchronous write strobe writes on clock edge, stretched while wait low
// - synchronous read captured next edge, or edge where wait goes high
// - asynchronous write strobe low one clock minimum; address/data one cycle around
// - asynchronous read same framing; data captured as strobe rises
// - chip select low from the first load until the tenure ends; the address keeps its value after
// - wait low stretches the strobe; wait may be tied high
// - control enable high only while granted and holding the bus
// - data enable high only while granted and carrying a write
// - mode input one selects asynchronous, zero synchronous timing
// - pass enable one lets host accesses through, zero blocks them
`timescale 1ns/10ps
module bmp_backend_port #(
	parameter int ADDR_W = bmp_pkg::ADDR_W,
	parameter int DATA_W = bmp_pkg::DATA_W
) (
	input  wire logic                   clk_sys,
	input  wire logic                   nrst,
	input  wire logic                   eng_valid,
	input  wire bmp_pkg::bmp_cmd_t      eng_cmd,
	output logic                        eng_taken,
	output logic                        eng_done,
	input  wire logic                   host_valid,
	input  wire bmp_pkg::bmp_cmd_t      host_cmd,
	output logic                        host_taken,
	output logic                        host_done,
	output logic [DATA_W-1:0]           rsp_rdata,
	input  wire logic                   backend_async_select,
	input  wire logic                   host_memory_pass_enable,
	output logic                        mem_request_n,
	input  wire logic                   mem_grant_n,
	output logic                        mem_tenure_n,
	output logic [1:0]                  mem_write_strobe_n,
	output logic                        mem_read_strobe_n,
	output logic                        mem_select_n,
	input  wire logic                   mem_hold_off_n,
	output logic [ADDR_W-1:0]           mem_address,
	output logic [DATA_W-1:0]           mem_write_data,
	input  wire logic [DATA_W-1:0]      mem_read_data,
	output logic                        control_drive_enable,
	output logic                        data_drive_enable
);
	import bmp_pkg::*;

	// lane split and the command carrier are fixed at 16 bits
	if (ADDR_W != bmp_pkg::ADDR_W || DATA_W != bmp_pkg::DATA_W) begin
		$error("bmp_backend_port: address and data must both be 16 bits");
	end

	bmp_state_t state_reg;
	bmp_state_t state_next;

	logic [1:0]  async_sync_reg;
	logic [1:0]  pass_sync_reg;
	logic        src_host_reg;
	logic        last_reg;
	logic        write_reg;
	// lane pattern kept from the load cycle for the async setup path
	logic [1:0]  mem_write_strobe_n_hold;

	// tie-offs still come from pins, so they are resynchronised
	wire logic   async_mode = async_sync_reg[1];
	wire logic   host_ok    = host_valid & pass_sync_reg[1];
	wire logic   any_valid  = eng_valid | host_ok;
	wire logic   pick_host  = ~eng_valid & host_ok;
	wire logic   granted    = ~mem_grant_n;
	wire logic   wait_clear = mem_hold_off_n;
	wire logic   src_valid  = src_host_reg ? host_ok : eng_valid;
	wire bmp_cmd_t cur_cmd  = src_host_reg ? host_cmd : eng_cmd;
	// continue the tenure only if the source said more words follow
	wire logic   go_next    = ~last_reg & src_valid;
	wire logic   go_release = last_reg;

	// lane mapping: bit one drives the upper byte, bit zero the lower
	function automatic logic [1:0] lane_strobes(input logic [1:0] byte_en);
		lane_strobes[LANE_HI] = ~byte_en[LANE_HI];
		lane_strobes[LANE_LO] = ~byte_en[LANE_LO];
	endfunction

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (any_valid) begin
					state_next = ST_REQ;
				end
			end
			ST_REQ: begin
				if (granted) begin
					state_next = ST_LOAD;
				end
			end
			ST_LOAD: begin
				state_next = async_mode ? ST_SETUP : ST_STROBE;
			end
			ST_SETUP: begin
				state_next = ST_STROBE;
			end
			ST_STROBE: begin
				if (wait_clear) begin
					state_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (go_release) begin
					state_next = ST_IDLE;
				end else if (go_next) begin
					state_next = ST_LOAD;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg      <= ST_IDLE;
			async_sync_reg <= SYNC_RST;
			pass_sync_reg  <= SYNC_RST;
		end else begin
			state_reg      <= state_next;
			async_sync_reg <= {async_sync_reg[0], backend_async_select};
			pass_sync_reg  <= {pass_sync_reg[0], host_memory_pass_enable};
		end
	end

	// arbitration handshake and tenure
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem_request_n        <= RST_STROBE_N;
			mem_tenure_n         <= RST_STROBE_N;
			control_drive_enable <= RST_ENABLE;
			src_host_reg         <= 1'b0;
		end else begin
			if (state_reg == ST_IDLE && any_valid) begin
				mem_request_n <= 1'b0;
				src_host_reg  <= pick_host;
			end
			if (state_reg == ST_REQ && granted) begin
				mem_request_n        <= 1'b1;
				mem_tenure_n         <= 1'b0;
				control_drive_enable <= 1'b1;
			end
			// grant is not looked at again until the next request
			if (state_reg == ST_HOLD && go_release) begin
				mem_tenure_n         <= 1'b1;
				control_drive_enable <= 1'b0;
			end
		end
	end

	// address, select, write data and data-bus enable
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem_address       <= RST_ADDR;
			mem_write_data    <= RST_DATA;
			mem_select_n      <= RST_STROBE_N;
			data_drive_enable <= RST_ENABLE;
			last_reg          <= 1'b1;
			write_reg         <= 1'b0;
		end else if (state_reg == ST_LOAD) begin
			mem_address       <= cur_cmd.addr;
			mem_write_data    <= cur_cmd.wdata;
			mem_select_n      <= 1'b0;
			data_drive_enable <= cur_cmd.write;
			last_reg          <= cur_cmd.last;
			write_reg         <= cur_cmd.write;
		end else if (state_reg == ST_HOLD && go_release) begin
			mem_select_n      <= 1'b1;
			data_drive_enable <= 1'b0;
		end
	end

	// strobes: asserted on entry to the strobe state, so at least one clock low;
	// in async mode the setup state gives the cycle of address lead
	wire logic strobe_start = (state_reg == ST_LOAD && !async_mode) || state_reg == ST_SETUP;
	wire logic strobe_end   = state_reg == ST_STROBE && wait_clear;
	// write_reg is still the previous word at load: a read after a write must not strobe writes
	wire logic wr_now       = (state_reg == ST_LOAD) ? cur_cmd.write : write_reg;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem_write_strobe_n <= LANES_OFF_N;
			mem_read_strobe_n  <= RST_STROBE_N;
		end else if (strobe_start) begin
			if (wr_now) begin
				mem_write_strobe_n <= (state_reg == ST_LOAD) ? lane_strobes(cur_cmd.byte_en)
				                                             : mem_write_strobe_n_hold;
			end else begin
				mem_read_strobe_n <= 1'b0;
			end
		end else if (strobe_end) begin
			mem_write_strobe_n <= LANES_OFF_N;
			mem_read_strobe_n  <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem_write_strobe_n_hold <= LANES_OFF_N;
		end else if (state_reg == ST_LOAD) begin
			mem_write_strobe_n_hold <= cur_cmd.write ? lane_strobes(cur_cmd.byte_en)
			                                         : LANES_OFF_N;
		end
	end

	// read data taken on the edge that ends the strobe, in either mode
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rsp_rdata <= RST_DATA;
		end else if (strobe_end && !write_reg) begin
			rsp_rdata <= mem_read_data;
		end
	end

	// taken pulses one cycle after load so the source can move on before hold
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			eng_taken  <= 1'b0;
			host_taken <= 1'b0;
			eng_done   <= 1'b0;
			host_done  <= 1'b0;
		end else begin
			eng_taken  <= state_reg == ST_LOAD && !src_host_reg;
			host_taken <= state_reg == ST_LOAD && src_host_reg;
			eng_done   <= strobe_end && !src_host_reg;
			host_done  <= strobe_end && src_host_reg;
		end
	end
endmodule

// *** bmp_backend_port_asserts.sv ***
// pin-level checks on the backend memory port
`timescale 1ns/10ps
module bmp_backend_port_asserts (
	input logic        clk_sys,
	input logic        nrst,
	input logic        backend_async_select,
	input logic        mem_request_n,
	input logic        mem_grant_n,
	input logic        mem_tenure_n,
	input logic [1:0]  mem_write_strobe_n,
	input logic        mem_read_strobe_n,
	input logic        mem_select_n,
	input logic        mem_hold_off_n,
	input logic [15:0] mem_address,
	input logic [15:0] mem_write_data,
	input logic        control_drive_enable,
	input logic        data_drive_enable
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire wr_on  = mem_write_strobe_n != 2'h3;
	wire any_on = wr_on || !mem_read_strobe_n;
	sequence s_open;
		backend_async_select && ($rose(wr_on) || $fell(mem_read_strobe_n));
	endsequence
	sequence s_close;
		backend_async_select && ($fell(wr_on) || $rose(mem_read_strobe_n));
	endsequence
	a_request_held: assert property (!mem_request_n && mem_grant_n |=> !mem_request_n)
		else $error("request dropped");
	a_grant_tenure: assert property (!mem_request_n && !mem_grant_n |=> !mem_tenure_n)
		else $error("no tenure");
	a_strobe_framed: assert property (any_on |-> !mem_select_n && !mem_tenure_n && control_drive_enable)
		else $error("strobe outside");
	a_enables_owned: assert property (control_drive_enable || data_drive_enable |-> !mem_tenure_n)
		else $error("enable outside");
	a_write_drives: assert property (wr_on |-> data_drive_enable && mem_read_strobe_n)
		else $error("write undriven");
	a_wait_stretch: assert property (any_on && !mem_hold_off_n |=> $stable(mem_write_strobe_n) && $stable(mem_read_strobe_n))
		else $error("wait ignored");
	a_strobe_ends: assert property (any_on && mem_hold_off_n |=> !any_on)
		else $error("strobe overlong");
	a_async_setup: assert property (s_open |-> !$past(mem_select_n) && $stable(mem_address))
		else $error("no setup");
	a_async_hold: assert property (s_close |-> !mem_select_n && $stable(mem_address) && ($rose(mem_read_strobe_n) || $stable(mem_write_data)))
		else $error("no hold");
endmodule
bind bmp_backend_port bmp_backend_port_asserts u_chk (.*);

// *** bmp_backend_port_test.sv ***
// self-checking bench for the backend memory port
`timescale 1ns/10ps
module bmp_backend_port_test;
	import bmp_pkg::*;
	logic        clk_sys = 1'b0, nrst = 1'b0, eng_valid = 1'b0, host_valid = 1'b0;
	logic        backend_async_select = 1'b0, host_memory_pass_enable = 1'b0;
	bmp_cmd_t    eng_cmd = '0, host_cmd = '0;
	logic        eng_taken, eng_done, host_taken, host_done, mem_request_n, mem_grant_n;
	logic        mem_tenure_n, mem_read_strobe_n, mem_select_n, mem_hold_off_n;
	logic        control_drive_enable, data_drive_enable;
	logic [1:0]  mem_write_strobe_n;
	logic [15:0] rsp_rdata, mem_address, mem_write_data, mem_read_data;
	logic [3:0]  gnt_delay = 4'h0, wait_cycles = 4'h0;
	int          err_total = 0, checks = 0;
	bmp_backend_port uut (.*);
	bmp_mem_model far (.*);
	always #4 clk_sys = ~clk_sys;
	initial begin
		#40000;
		err_total++;
		stop_test();
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic bmp_cmd_t cmd(logic w, logic [1:0] be, logic [15:0] a, d, logic l);
		cmd = {w, be, a, d, l};
	endfunction
	task automatic rst(input logic a, input logic p);
		nrst <= 1'b0;
		backend_async_select <= a;
		host_memory_pass_enable <= p;
		repeat (10) @(posedge clk_sys);
		chk({8'h00, mem_request_n, mem_tenure_n, mem_select_n, mem_read_strobe_n,
			mem_write_strobe_n, control_drive_enable, data_drive_enable}, 16'h00fc);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask
	// valid is dropped after taken so a held word is never taken twice
	task automatic xfer(input logic h, input bmp_cmd_t c, input logic [15:0] exp);
		int n;
		n = 0;
		if (h) begin
			host_valid <= 1'b1;
			host_cmd   <= c;
		end else begin
			eng_valid <= 1'b1;
			eng_cmd   <= c;
		end
		do begin
			@(negedge clk_sys);
			n++;
		end while ((h ? host_taken : eng_taken) !== 1'b1 && n < 40);
		@(posedge clk_sys);
		host_valid <= 1'b0;
		eng_valid  <= 1'b0;
		do begin
			@(negedge clk_sys);
			n++;
		end while ((h ? host_done : eng_done) !== 1'b1 && n < 80);
		chk({15'h0000, n >= 40}, 16'h0000);
		if (!c.write) chk(rsp_rdata, exp);
		@(posedge clk_sys);
	endtask
	task automatic sync_burst();
		rst(1'b0, 1'b0);
		xfer(1'b0, cmd(1'b1, 2'h3, 16'h0010, 16'h1234, 1'b0), 16'h0000);
		xfer(1'b0, cmd(1'b1, 2'h1, 16'h0010, 16'habcd, 1'b0), 16'h0000);
		xfer(1'b0, cmd(1'b0, 2'h3, 16'h0010, 16'h0000, 1'b1), 16'h12cd);
	endtask
	task automatic host_blocked();
		int seen;
		seen = 0;
		host_valid <= 1'b1;
		host_cmd   <= cmd(1'b0, 2'h3, 16'h0010, 16'h0000, 1'b1);
		repeat (20) begin
			@(negedge clk_sys);
			seen += host_taken | !mem_request_n;
		end
		chk(seen[15:0], 16'h0000);
		@(posedge clk_sys);
		host_valid <= 1'b0;
	endtask
	task automatic slow_sync();
		gnt_delay   <= 4'h3;
		wait_cycles <= 4'h2;
		xfer(1'b0, cmd(1'b1, 2'h2, 16'h0010, 16'h5a00, 1'b1), 16'h0000);
		xfer(1'b0, cmd(1'b0, 2'h3, 16'h0010, 16'h0000, 1'b1), 16'h5acd);
	endtask
	task automatic async_host();
		rst(1'b1, 1'b1);
		xfer(1'b1, cmd(1'b1, 2'h3, 16'h0020, 16'hbeef, 1'b1), 16'h0000);
		xfer(1'b0, cmd(1'b0, 2'h3, 16'h0020, 16'h0000, 1'b1), 16'hbeef);
		wait_cycles <= 4'h0;
		xfer(1'b1, cmd(1'b0, 2'h3, 16'h0010, 16'h0000, 1'b1), 16'h5acd);
	endtask
	task automatic stop_test();
		if (err_total == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		sync_burst();
		host_blocked();
		slow_sync();
		async_host();
		stop_test();
	end
endmodule

// *** bmp_mem_model.sv ***
// arbiter and word memory on the far side of the port
`timescale 1ns/10ps
module bmp_mem_model (
	input  logic        clk_sys,
	input  logic        nrst,
	input  logic [3:0]  gnt_delay,
	input  logic [3:0]  wait_cycles,
	input  logic        mem_request_n,
	output logic        mem_grant_n,
	input  logic        mem_tenure_n,
	input  logic [1:0]  mem_write_strobe_n,
	input  logic        mem_read_strobe_n,
	input  logic        mem_select_n,
	output logic        mem_hold_off_n,
	input  logic [15:0] mem_address,
	input  logic [15:0] mem_write_data,
	output logic [15:0] mem_read_data
);
	logic [15:0] ram [0:255];
	logic [3:0]  gcnt_reg;
	logic [3:0]  wcnt_reg;
	wire         busy = !mem_read_strobe_n || mem_write_strobe_n != 2'h3;
	wire [7:0]   idx = mem_address[7:0];
	// inverse while idle, so a stale word cannot pass
	assign mem_read_data = mem_read_strobe_n ? ~ram[idx] : ram[idx];
	assign mem_hold_off_n = !(busy && wcnt_reg < wait_cycles);
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem_grant_n <= 1'b1;
			gcnt_reg    <= 4'h0;
			wcnt_reg    <= 4'h0;
		end else begin
			gcnt_reg    <= mem_request_n ? 4'h0 : gcnt_reg + 4'h1;
			mem_grant_n <= !(!mem_request_n && mem_tenure_n && gcnt_reg >= gnt_delay);
			wcnt_reg    <= busy ? wcnt_reg + 4'h1 : 4'h0;
			if (!mem_select_n && mem_hold_off_n && !mem_write_strobe_n[1]) ram[idx][15:8] <= mem_write_data[15:8];
			if (!mem_select_n && mem_hold_off_n && !mem_write_strobe_n[0]) ram[idx][7:0] <= mem_write_data[7:0];
		end
	end
endmodule

// *** bmp_pkg.sv ***
// shared constants and command carrier for the backend memory port
package bmp_pkg;
	localparam int ADDR_W    = 16;
	localparam int DATA_W    = 16;
	localparam int LANES     = 2;
	localparam int LANE_HI   = 1;
	localparam int LANE_LO   = 0;
	localparam int LANE_BITS = 8;

	localparam logic         RST_STROBE_N = 1'b1;
	localparam logic         RST_ENABLE   = 1'b0;
	localparam logic [15:0]  RST_ADDR     = 16'h0000;
	localparam logic [15:0]  RST_DATA     = 16'h0000;
	localparam logic [1:0]   LANES_OFF_N  = 2'h3;
	localparam logic [1:0]   SYNC_RST     = 2'h0;

	// one word access asked of the port
	typedef struct packed {
		logic              write;
		logic [LANES-1:0]  byte_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              last;
	} bmp_cmd_t;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_REQ    = 6'b000010,
		ST_LOAD   = 6'b000100,
		ST_SETUP  = 6'b001000,
		ST_STROBE = 6'b010000,
		ST_HOLD   = 6'b100000
	} bmp_state_t;
endpackage
